// >>> src/flash_burst_config.v
// command decode, burst configuration and bank map for the flash
`timescale 1ns/1ps
`include "flash_cfg_regs.vh"
module flash_burst_config (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire [20:0] addr_i,
  input wire [7:0] data_i,
  input wire write_n_i,
  input wire address_valid_strobe_n_i,
  input wire burst_req_i,
  input wire algo_done_i,
  input wire timeout_flag_bit_i,
  input wire lock_busy_i,
  output reg [1:0] bank_o,
  output reg [6:0] sector_o,
  output reg boot_sector_o,
  output reg read_valid_o,
  output reg [7:0] config_o,
  output reg config_written_o,
  output reg sync_active_o,
  output reg ready_o,
  output reg data_valid_o,
  output reg [20:0] burst_addr_o,
  output reg undefined_o,
  output reg [7:0] bank_states_o
);
  // pins come from outside the clock domain
  // limitation: address and data are taken with the strobe, so the host must hold them
  // steady while the write strobe is low; a bit that settles late is read one write too late
  reg [20:0] addr_s1;
  reg [20:0] addr_s2;
  reg [7:0] data_s1;
  reg [7:0] data_s2;
  reg we_s1;
  reg we_s2;
  reg avd_s1;
  reg avd_s2;
  reg breq_s1;
  reg breq_s2;
  reg done_s1;
  reg done_s2;
  reg to_s1;
  reg to_s2;
  reg lk_s1;
  reg lk_s2;
  // edge detectors reset to the idle high level of their pins, so no false edge follows reset
  reg we_prev;
  reg avd_prev;
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_s1 <= 21'h0;
      addr_s2 <= 21'h0;
      data_s1 <= 8'h0;
      data_s2 <= 8'h0;
      we_s1 <= 1'b1;
      we_s2 <= 1'b1;
      avd_s1 <= 1'b1;
      avd_s2 <= 1'b1;
      breq_s1 <= 1'b0;
      breq_s2 <= 1'b0;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      to_s1 <= 1'b0;
      to_s2 <= 1'b0;
      lk_s1 <= 1'b0;
      lk_s2 <= 1'b0;
      we_prev <= 1'b1;
      avd_prev <= 1'b1;
    end else begin
      addr_s1 <= addr_i;
      addr_s2 <= addr_s1;
      data_s1 <= data_i;
      data_s2 <= data_s1;
      we_s1 <= write_n_i;
      we_s2 <= we_s1;
      avd_s1 <= address_valid_strobe_n_i;
      avd_s2 <= avd_s1;
      breq_s1 <= burst_req_i;
      breq_s2 <= breq_s1;
      done_s1 <= algo_done_i;
      done_s2 <= done_s1;
      to_s1 <= timeout_flag_bit_i;
      to_s2 <= to_s1;
      lk_s1 <= lock_busy_i;
      lk_s2 <= lk_s1;
      we_prev <= we_s2;
      avd_prev <= avd_s2;
    end
  end
  wire wr_stb = we_prev & ~we_s2;
  wire avd_fall = avd_prev & ~avd_s2;

  // address decode
  function [6:0] sector_of;
    input [20:0] a;
    begin
      if (a[20:15] == 6'h00)
        sector_of = {4'h0, a[14:12]} >> 1; // see RQ2
      else if (a[20:15] == 6'h3f)
        sector_of = 7'd66 + ({4'h0, a[14:12]} >> 1); // see RQ2
      else
        sector_of = 7'd3 + {1'b0, a[20:15]}; // see RQ2
    end
  endfunction
  wire [1:0] bank_w = addr_s2[20:19]; // see RQ1
  wire [6:0] sector_w = sector_of(addr_s2);

  // command sequencer
  localparam SEQ_IDLE = 3'h0;
  localparam SEQ_U1 = 3'h1;
  localparam SEQ_U2 = 3'h2;
  localparam SEQ_PROG = 3'h3;
  localparam SEQ_E1 = 3'h4;
  localparam SEQ_E2 = 3'h5;
  localparam SEQ_E3 = 3'h6;
  localparam SEQ_LOST = 3'h7;
  reg [2:0] seq_reg;
  reg [2:0] seq_next;
  reg cmd_prog;
  reg cmd_erase;
  reg cmd_susp;
  reg cmd_resume;
  reg cmd_ident;
  reg cmd_reset;
  reg cmd_cfg;
  wire [11:0] low = addr_s2[11:0];
  wire [7:0] d = data_s2;
  always @* begin
    seq_next = seq_reg;
    cmd_prog = 1'b0;
    cmd_erase = 1'b0;
    cmd_susp = 1'b0;
    cmd_resume = 1'b0;
    cmd_ident = 1'b0;
    cmd_reset = 1'b0;
    cmd_cfg = 1'b0;
    if (wr_stb) begin
      if (d == `CMD_RESET) begin
        cmd_reset = 1'b1; // see RQ3
        seq_next = SEQ_IDLE;
      end else begin
        case (seq_reg)
          SEQ_IDLE: begin
            if (d == `CMD_UNLOCK_A && low == `CMD_LOW_ADDR_A)
              seq_next = SEQ_U1; // see RQ25
            else if (d == `CMD_SUSPEND)
              cmd_susp = 1'b1;
            else if (d == `CMD_RESUME)
              cmd_resume = 1'b1;
            else
              seq_next = SEQ_LOST; // see RQ3
          end
          SEQ_U1: seq_next = (d == `CMD_UNLOCK_B && low == `CMD_LOW_ADDR_B) ? SEQ_U2 : SEQ_LOST; // see RQ25
          SEQ_U2: begin
            seq_next = SEQ_IDLE;
            if (low != `CMD_LOW_ADDR_A)
              seq_next = SEQ_LOST;
            else if (d == `CMD_CONFIG)
              cmd_cfg = 1'b1; // see RQ11
            else if (d == `CMD_PROGRAM)
              seq_next = SEQ_PROG;
            else if (d == `CMD_ERASE)
              seq_next = SEQ_E1;
            else if (d == `CMD_AUTOSEL)
              cmd_ident = 1'b1;
            else
              seq_next = SEQ_LOST;
          end
          SEQ_PROG: begin
            cmd_prog = 1'b1;
            seq_next = SEQ_IDLE;
          end
          SEQ_E1: seq_next = (d == `CMD_UNLOCK_A && low == `CMD_LOW_ADDR_A) ? SEQ_E2 : SEQ_LOST;
          SEQ_E2: seq_next = (d == `CMD_UNLOCK_B && low == `CMD_LOW_ADDR_B) ? SEQ_E3 : SEQ_LOST;
          SEQ_E3: begin
            cmd_erase = 1'b1;
            seq_next = SEQ_IDLE;
          end
          SEQ_LOST: seq_next = SEQ_LOST; // see RQ3
          default: seq_next = SEQ_LOST;
        endcase
      end
    end
  end

  // per-bank trackers
  wire [11:0] st_w;
  wire [3:0] rd_ok_w;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : bank_g
      bank_tracker u_bank (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .sel_i(bank_w == g),
        .start_prog_i(cmd_prog),
        .start_erase_i(cmd_erase),
        .suspend_i(cmd_susp),
        .resume_i(cmd_resume),
        .ident_i(cmd_ident),
        .reset_cmd_i(cmd_reset),
        .algo_done_i(done_s2),
        .timeout_i(to_s2),
        .sector_i(sector_w),
        .read_sector_i(sector_w),
        .state_o(st_w[3*g +: 3]),
        .susp_sector_o(),
        .read_ok_o(rd_ok_w[g])
      );
    end
  endgenerate
  wire any_busy = lk_s2 | (st_w[2:0] == `BANK_ST_BUSY) | (st_w[5:3] == `BANK_ST_BUSY) |
    (st_w[8:6] == `BANK_ST_BUSY) | (st_w[11:9] == `BANK_ST_BUSY) |
    (st_w[2:0] == `BANK_ST_SUSP_PROG) | (st_w[5:3] == `BANK_ST_SUSP_PROG) |
    (st_w[8:6] == `BANK_ST_SUSP_PROG) | (st_w[11:9] == `BANK_ST_SUSP_PROG);

  // burst configuration register
  reg [7:0] cfg_reg;
  reg [7:0] cfg_next;
  always @* begin
    cfg_next = cfg_reg;
    if (cmd_cfg && !any_busy) begin // see RQ13
      cfg_next = addr_s2[19:12]; // see RQ9 RQ22
      if (addr_s2[14:12] > `WAIT_MAX_CODE)
        cfg_next[`CFG_WAIT_HI:`CFG_WAIT_LO] = cfg_reg[`CFG_WAIT_HI:`CFG_WAIT_LO]; // see RQ26
    end
  end
  wire sync_en = ~cfg_reg[`CFG_SYNC_BIT] & config_written_o; // see RQ10 RQ14
  wire [3:0] init_cycles = `WAIT_BASE + {1'b0, cfg_reg[`CFG_WAIT_HI:`CFG_WAIT_LO]}; // see RQ16
  wire early_ready = ~cfg_reg[`CFG_READY_BIT] & (cfg_reg[`CFG_WAIT_HI:`CFG_WAIT_LO] != 3'h0); // see RQ18 RQ23
  // active edge bit is exported for the output stage; this core is single-edge so it only steers pads
  wire [1:0] len_sel = {cfg_reg[`CFG_LEN_HI], cfg_reg[`CFG_LEN_LO]}; // see RQ21
  wire [20:0] wrap_mask = (len_sel == 2'h1) ? 21'h7 : (len_sel == 2'h2) ? 21'hf :
    (len_sel == 2'h3) ? 21'h1f : `MAX_WORD_ADDR;

  // burst timing
  reg [3:0] cnt_reg;
  reg bursting;
  wire [3:0] cnt_inc = cnt_reg + 4'h1;
  wire [20:0] addr_inc = burst_addr_o + 21'h1; // see RQ24 natural wrap of 21 bits
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq_reg <= SEQ_IDLE;
      cfg_reg <= `CFG_RESET; // see RQ12 RQ17
      config_written_o <= 1'b0;
      config_o <= `CFG_RESET;
      cnt_reg <= 4'h0;
      bursting <= 1'b0;
      ready_o <= 1'b0;
      data_valid_o <= 1'b0;
      burst_addr_o <= 21'h0;
      sync_active_o <= 1'b0;
      bank_o <= 2'h0;
      sector_o <= 7'h0;
      boot_sector_o <= 1'b0;
      read_valid_o <= 1'b1; // see RQ4
      undefined_o <= 1'b0;
      bank_states_o <= 8'h0;
    end else begin
      seq_reg <= seq_next;
      cfg_reg <= cfg_next;
      config_o <= cfg_next;
      if (cmd_cfg && !any_busy)
        config_written_o <= 1'b1;
      // follows the value being loaded, so the flag never lags a return to asynchronous mode
      sync_active_o <= ~cfg_next[`CFG_SYNC_BIT] & (config_written_o | (cmd_cfg & ~any_busy)); // see RQ10 RQ14
      bank_o <= bank_w;
      sector_o <= sector_w;
      boot_sector_o <= (sector_w < `BOOT_SLOTS) || (sector_w > 7'd65);
      read_valid_o <= rd_ok_w[bank_w] & (seq_next != SEQ_LOST);
      undefined_o <= (seq_next == SEQ_LOST);
      bank_states_o <= {st_w[10:9], st_w[7:6], st_w[4:3], st_w[1:0]};
      if (avd_fall && breq_s2 && sync_en) begin // see RQ15
        bursting <= 1'b1;
        cnt_reg <= 4'h1;
        burst_addr_o <= addr_s2;
        data_valid_o <= 1'b0;
        ready_o <= 1'b0;
      end else if (bursting && !breq_s2) begin
        bursting <= 1'b0;
        cnt_reg <= 4'h0;
        data_valid_o <= 1'b0;
        ready_o <= 1'b0;
      end else if (bursting) begin
        if (cnt_reg < init_cycles) begin
          cnt_reg <= cnt_inc;
          ready_o <= early_ready && (cnt_inc == init_cycles);
          if (cnt_inc == init_cycles) begin
            data_valid_o <= 1'b1;
            ready_o <= 1'b1;
          end
        end else begin
          burst_addr_o <= (burst_addr_o & ~wrap_mask) | (addr_inc & wrap_mask); // see RQ21 RQ24
          data_valid_o <= 1'b1;
          ready_o <= 1'b1;
        end
        if (early_ready && cnt_inc == init_cycles - 4'h1)
          ready_o <= 1'b1; // see RQ23
      end
    end
  end
endmodule // flash_burst_config

// >>> src/flash_cfg_regs.vh
// constants for the flash burst configuration and bank map block
// How it works
// RQ1: four banks split on address bits 20:19
// RQ2: four boot sectors each end, 8 Kword
// RQ3: bad sequence locks; only reset command recovers
// RQ4: array read right after power-up
// RQ5: bank returns to read when algorithm ends
// RQ6: suspend gives read except suspended sectors
// RQ7: program during suspend returns to suspend-read
// RQ8: host resets bank after timeout or ident
// RQ9: register holds wait, length, edge, ready, mode
// RQ10: no burst until register written
// RQ11: three cycles, C0h at 555h latches A19:12
// RQ12: reset restores asynchronous default
// RQ13: no config change while busy
// RQ14: bit 19 one async, zero burst
// RQ15: initial cycles counted from address strobe
// RQ16: wait codes 0..5 give 2..7 cycles
// RQ17: default seven initial access cycles
// RQ18: two cycles forces ready with data
// RQ19: host picks wait count for clock rate
// RQ20: host always writes config sequence
// RQ21: bits 16:15 select burst length
// RQ22: bit 17 selects active clock edge
// RQ23: bit 18 selects ready timing
// RQ24: continuous burst wraps top to bottom
// RQ25: unlock AAh at 555h, 55h at 2AAh
// RQ26: wait codes six, seven keep old value
`ifndef FLASH_CFG_REGS_VH
`define FLASH_CFG_REGS_VH
`define CFG_RESET 8'he5
`define CFG_SYNC_BIT 7
`define CFG_READY_BIT 6
`define CFG_EDGE_BIT 5
`define CFG_LEN_HI 4
`define CFG_LEN_LO 3
`define CFG_WAIT_HI 2
`define CFG_WAIT_LO 0
`define CMD_LOW_ADDR_A 12'h555
`define CMD_LOW_ADDR_B 12'h2aa
`define CMD_UNLOCK_A 8'haa
`define CMD_UNLOCK_B 8'h55
`define CMD_CONFIG 8'hc0
`define CMD_RESET 8'hf0
`define CMD_SUSPEND 8'hb0
`define CMD_RESUME 8'h30
`define CMD_AUTOSEL 8'h90
`define CMD_PROGRAM 8'ha0
`define CMD_ERASE 8'h80
`define WAIT_MAX_CODE 3'h5
`define WAIT_BASE 4'h2
`define BOOT_SLOTS 7'd4
`define MAX_WORD_ADDR 21'h1fffff
`define BANK_ST_READ 3'h0
`define BANK_ST_BUSY 3'h1
`define BANK_ST_SUSP 3'h2
`define BANK_ST_SUSP_PROG 3'h3
`define BANK_ST_IDENT 3'h4
`define BANK_ST_TIMEOUT 3'h5
`endif

// >>> src/bank_tracker.v
// per-bank read state tracker
`timescale 1ns/1ps
`include "flash_cfg_regs.vh"
module bank_tracker (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire sel_i,
  input wire start_prog_i,
  input wire start_erase_i,
  input wire suspend_i,
  input wire resume_i,
  input wire ident_i,
  input wire reset_cmd_i,
  input wire algo_done_i,
  input wire timeout_i,
  input wire [6:0] sector_i,
  input wire [6:0] read_sector_i,
  output reg [2:0] state_o,
  output reg [6:0] susp_sector_o,
  output wire read_ok_o
);
  reg [6:0] erase_sector_reg;
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_o <= `BANK_ST_READ; // see RQ4
      susp_sector_o <= 7'h7f;
      erase_sector_reg <= 7'h7f;
    end else begin
      case (state_o)
        `BANK_ST_READ: begin
          if (sel_i && ident_i)
            state_o <= `BANK_ST_IDENT;
          else if (sel_i && (start_prog_i || start_erase_i)) begin
            state_o <= `BANK_ST_BUSY;
            if (start_erase_i)
              erase_sector_reg <= sector_i;
          end
        end
        `BANK_ST_BUSY: begin
          if (timeout_i)
            state_o <= `BANK_ST_TIMEOUT;
          else if (sel_i && suspend_i && erase_sector_reg != 7'h7f) begin
            state_o <= `BANK_ST_SUSP; // see RQ6
            susp_sector_o <= erase_sector_reg;
          end else if (algo_done_i) begin
            state_o <= `BANK_ST_READ; // see RQ5
            erase_sector_reg <= 7'h7f;
          end
        end
        `BANK_ST_SUSP: begin
          if (sel_i && start_prog_i)
            state_o <= `BANK_ST_SUSP_PROG;
          else if (sel_i && resume_i) begin
            state_o <= `BANK_ST_BUSY;
            susp_sector_o <= 7'h7f;
          end
        end
        `BANK_ST_SUSP_PROG: begin
          if (timeout_i)
            state_o <= `BANK_ST_TIMEOUT;
          else if (algo_done_i)
            state_o <= `BANK_ST_SUSP; // see RQ7
        end
        `BANK_ST_IDENT, `BANK_ST_TIMEOUT: begin
          if (sel_i && reset_cmd_i)
            state_o <= (susp_sector_o != 7'h7f) ? `BANK_ST_SUSP : `BANK_ST_READ; // see RQ8
        end
        default: state_o <= `BANK_ST_READ;
      endcase
    end
  end
  // suspended sector stays unreadable while in suspend states
  assign read_ok_o = (state_o == `BANK_ST_READ) ||
    ((state_o == `BANK_ST_SUSP || state_o == `BANK_ST_SUSP_PROG) && read_sector_i != susp_sector_o); // see RQ6
endmodule // bank_tracker

// >>> testbench/flash_burst_config_sva.sv
// assertion checker for the flash burst configuration block
`timescale 1ns/1ps
module flash_burst_config_sva (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire [20:0] addr_i,
  input wire lock_busy_i,
  input wire [1:0] bank_o,
  input wire [6:0] sector_o,
  input wire [7:0] config_o,
  input wire config_written_o,
  input wire sync_active_o,
  input wire ready_o,
  input wire data_valid_o,
  input wire [20:0] burst_addr_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // six quiet cycles cover the two-flop input path plus the output register
  sequence s_addr_steady;
    $stable(addr_i) [*6];
  endsequence
  sequence s_streaming;
    data_valid_o ##1 data_valid_o;
  endsequence
  a_bank_decode: assert property (s_addr_steady |-> bank_o == addr_i[20:19])
    else $error("bank index wrong");
  a_sector_map: assert property (s_addr_steady |-> sector_o == (addr_i[20:15] == 6'h00 ? {5'h00, addr_i[14:13]} :
    addr_i[20:15] == 6'h3f ? 7'h42 + addr_i[14:13] : {1'b0, addr_i[20:15]} + 7'h03))
    else $error("sector index wrong");
  a_reset_default: assert property ($rose(reset_n_i) |-> config_o == 8'he5 && !config_written_o)
    else $error("reset configuration wrong");
  a_sync_gate: assert property (sync_active_o |-> config_written_o && !config_o[7])
    else $error("burst enabled without setting");
  a_lock_freeze: assert property (lock_busy_i [*6] |=> $stable(config_o))
    else $error("configuration changed while busy");
  a_ready_with: assert property ($rose(data_valid_o) ##0 (config_o[6] || config_o[2:0] == 3'h0) |-> ready_o)
    else $error("ready missing with data");
  a_ready_early: assert property ($rose(data_valid_o) && !config_o[6] && config_o[2:0] != 3'h0
    |-> $past(ready_o))
    else $error("ready not one cycle early");
  a_burst_linear: assert property (s_streaming ##0 config_o[4:3] == 2'h0
    |-> burst_addr_o == $past(burst_addr_o) + 21'h000001)
    else $error("continuous pointer wrong");
  a_burst_wrap8: assert property (s_streaming ##0 config_o[4:3] == 2'h1
    |-> burst_addr_o == {$past(burst_addr_o[20:3]), $past(burst_addr_o[2:0]) + 3'h1})
    else $error("eight word wrap wrong");
endmodule // flash_burst_config_sva
bind flash_burst_config flash_burst_config_sva chk_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .addr_i(addr_i), .lock_busy_i(lock_busy_i), .bank_o(bank_o), .sector_o(sector_o), .config_o(config_o),
  .config_written_o(config_written_o), .sync_active_o(sync_active_o), .ready_o(ready_o),
  .data_valid_o(data_valid_o), .burst_addr_o(burst_addr_o));

// >>> testbench/host_bus_model.sv
// host memory controller model driving the flash command pins
`timescale 1ns/1ps
module host_bus_model (
  input wire sys_clk_i,
  output reg [20:0] addr_o,
  output reg [7:0] data_o,
  output reg write_n_o,
  output reg address_valid_strobe_n_o,
  output reg burst_req_o
);
  initial begin
    addr_o = 21'h000000;
    data_o = 8'h00;
    write_n_o = 1'b1;
    address_valid_strobe_n_o = 1'b1;
    burst_req_o = 1'b0;
  end
  // slow cycles so the synchronised strobe sees both levels
  task wr(input [20:0] a, input [7:0] d);
    begin
      @(negedge sys_clk_i);
      addr_o = a;
      data_o = d;
      write_n_o = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      write_n_o = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      data_o = ~d; // released bus shows the inverse, not a stale copy
    end
  endtask
  task unlock;
    begin
      wr(21'h000555, 8'haa);
      wr(21'h0002aa, 8'h55);
    end
  endtask
  task set_config(input [7:0] s);
    begin
      unlock;
      wr({1'b0, s, 12'h555}, 8'hc0);
    end
  endtask
  task cmd_reset;
    wr(21'h000000, 8'hf0);
  endtask
endmodule // host_bus_model

// >>> testbench/tb_top.sv
// self-checking bench for the flash burst configuration block
`timescale 1ns/1ps
module tb_top;
  localparam logic [29:0] map_tab [0:7] = '{{21'h000000, 7'h00, 2'h0}, {21'h007fff, 7'h03, 2'h0},
    {21'h008000, 7'h04, 2'h0}, {21'h07ffff, 7'h12, 2'h0}, {21'h080000, 7'h13, 2'h1},
    {21'h100000, 7'h23, 2'h2}, {21'h1f7fff, 7'h41, 2'h3}, {21'h1fe000, 7'h45, 2'h3}};
  reg sys_clk_i = 1'b0;
  reg reset_n_i = 1'b0;
  reg algo_done_i = 1'b0;
  reg lock_busy_i = 1'b0;
  reg timeout_flag_bit_i = 1'b0;
  reg rdy_early = 1'b0;
  integer miscompares = 0;
  integer comparisons = 0;
  integer l0, l8, l5, k;
  wire [20:0] addr_w, burst_addr_o;
  wire [7:0] data_w, config_o, bank_states_o;
  wire [6:0] sector_o;
  wire [1:0] bank_o;
  wire write_n_w, strobe_n_w, req_w, boot_sector_o, read_valid_o, config_written_o, sync_active_o;
  wire ready_o, data_valid_o, undefined_o;
  always #50 sys_clk_i = ~sys_clk_i;
  host_bus_model host_u (.sys_clk_i(sys_clk_i), .addr_o(addr_w), .data_o(data_w), .write_n_o(write_n_w),
    .address_valid_strobe_n_o(strobe_n_w), .burst_req_o(req_w));
  flash_burst_config dut_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_w), .data_i(data_w),
    .write_n_i(write_n_w), .address_valid_strobe_n_i(strobe_n_w), .burst_req_i(req_w),
    .algo_done_i(algo_done_i), .timeout_flag_bit_i(timeout_flag_bit_i), .lock_busy_i(lock_busy_i), .bank_o(bank_o),
    .sector_o(sector_o), .boot_sector_o(boot_sector_o), .read_valid_o(read_valid_o), .config_o(config_o),
    .config_written_o(config_written_o), .sync_active_o(sync_active_o), .ready_o(ready_o),
    .data_valid_o(data_valid_o), .burst_addr_o(burst_addr_o), .undefined_o(undefined_o),
    .bank_states_o(bank_states_o));
  task conclude;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // the count starts at the strobe, so only differences between runs are absolute
  task burst(input [20:0] a, input want, output integer lat);
    begin
      host_u.addr_o = a;
      host_u.burst_req_o = 1'b1;
      host_u.address_valid_strobe_n_o = 1'b0;
      idle(1);
      host_u.address_valid_strobe_n_o = 1'b1;
      lat = 1;
      rdy_early = 1'b0;
      while (data_valid_o !== 1'b1 && lat < 15) begin
        rdy_early = ready_o;
        idle(1);
        lat = lat + 1;
      end
      check("valid", data_valid_o, want);
      check("ready", ready_o, want);
      if (want && lat == 15) conclude;
      if (want) check("start", burst_addr_o, a);
      idle(4);
      host_u.burst_req_o = 1'b0;
      idle(6);
    end
  endtask
  task t_defaults;
    begin
      check("config", config_o, 8'he5);
      check("read", read_valid_o, 1'b1);
      check("written", config_written_o, 1'b0);
      burst(21'h000000, 1'b0, l0);
    end
  endtask
  task t_bank_map;
    for (k = 0; k < 8; k = k + 1) begin
      host_u.addr_o = map_tab[k][29:9];
      idle(6);
      check("bank", bank_o, map_tab[k][1:0]);
      check("sector", sector_o, map_tab[k][8:2]);
      check("boot", boot_sector_o, map_tab[k][8:2] < 7'h04 || map_tab[k][8:2] > 7'h41);
    end
  endtask
  task t_config_burst;
    begin
      host_u.set_config(8'h00); // the shortest count suits this slow clock
      check("config", config_o, 8'h00);
      check("written", config_written_o, 1'b1);
      check("sync", sync_active_o, 1'b1);
      burst(21'h000103, 1'b1, l0);
      check("early", rdy_early, 1'b0);
      host_u.set_config(8'h4e);
      check("config", config_o, 8'h48);
      burst(21'h000105, 1'b1, l8);
      check("latency", l8, l0);
      host_u.set_config(8'h05);
      burst(21'h1ffffe, 1'b1, l5);
      check("early", rdy_early, 1'b1);
      check("latency", l5 - l0, 32'h5);
    end
  endtask
  task t_bad_seq;
    begin
      host_u.wr(21'h000555, 8'haa);
      host_u.wr(21'h000123, 8'h12);
      check("undefined", undefined_o, 1'b1);
      host_u.set_config(8'h40);
      check("config", config_o, 8'h05);
      host_u.cmd_reset;
      check("undefined", undefined_o, 1'b0);
    end
  endtask
  task t_busy;
    begin
      lock_busy_i = 1'b1;
      host_u.set_config(8'h40);
      check("config", config_o, 8'h05);
      lock_busy_i = 1'b0;
      host_u.unlock;
      host_u.wr(21'h000555, 8'ha0);
      host_u.wr(21'h000100, 8'h5a);
      check("bank0", bank_states_o[1:0], 2'h1);
      host_u.set_config(8'h40);
      check("config", config_o, 8'h05);
      finish_algo;
      check("bank0", bank_states_o[1:0], 2'h0);
    end
  endtask
  task finish_algo;
    begin
      algo_done_i = 1'b1;
      idle(1);
      algo_done_i = 1'b0;
      idle(4);
    end
  endtask
  task t_suspend;
    begin
      host_u.unlock;
      host_u.wr(21'h000555, 8'h80);
      host_u.wr(21'h000555, 8'haa);
      host_u.wr(21'h0002aa, 8'h55);
      host_u.wr(21'h008000, 8'h30);
      check("bank0", bank_states_o[1:0], 2'h1);
      host_u.wr(21'h000000, 8'hb0);
      check("bank0", bank_states_o[1:0], 2'h2);
      host_u.addr_o = 21'h008000;
      idle(6);
      check("read", read_valid_o, 1'b0);
      host_u.addr_o = 21'h010000;
      idle(6);
      check("read", read_valid_o, 1'b1);
      host_u.unlock;
      host_u.wr(21'h000555, 8'ha0);
      host_u.wr(21'h010000, 8'h5a);
      check("bank0", bank_states_o[1:0], 2'h3);
      finish_algo;
      check("bank0", bank_states_o[1:0], 2'h2);
      host_u.addr_o = 21'h008000;
      idle(6);
      check("read", read_valid_o, 1'b0);
      host_u.wr(21'h000000, 8'h30);
      finish_algo;
      check("bank0", bank_states_o[1:0], 2'h0);
    end
  endtask
  task t_timeout;
    begin
      host_u.unlock;
      host_u.wr(21'h000555, 8'ha0);
      host_u.wr(21'h080000, 8'h5a);
      check("bank1", bank_states_o[3:2], 2'h1);
      timeout_flag_bit_i = 1'b1;
      finish_algo;
      timeout_flag_bit_i = 1'b0;
      check("bank1", bank_states_o[3:2], 2'h1);
      check("read", read_valid_o, 1'b0);
      host_u.wr(21'h080000, 8'hf0);
      check("bank1", bank_states_o[3:2], 2'h0);
      check("read", read_valid_o, 1'b1);
    end
  endtask
  task t_hw_reset;
    begin
      host_u.set_config(8'he5);
      check("config", config_o, 8'he5);
      check("sync", sync_active_o, 1'b0);
      burst(21'h000200, 1'b0, l0);
      host_u.set_config(8'h00);
      reset_n_i = 1'b0;
      idle(2);
      reset_n_i = 1'b1;
      idle(3);
      check("config", config_o, 8'he5);
      check("written", config_written_o, 1'b0);
      check("sync", sync_active_o, 1'b0);
    end
  endtask
  initial begin
    repeat (12) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    idle(3);
    t_defaults;
    t_bank_map;
    t_config_burst;
    t_bad_seq;
    t_busy;
    t_suspend;
    t_timeout;
    t_hw_reset;
    conclude;
  end
endmodule // tb_top
